/* hcac_csr.sv */
// Purpose: csr access steering, privilege tracking and overflow shadow
// Assumes: pipeline issues at most one csr access per request pulse
// Notes:   answer comes one cycle after the request
// Functional notes
// R1: shadow register mirrors overflow flags 3 to 31
// R2: machine level reads shadow ungated
// R3: host supervisor gates by machine counter enable
// R4: guest supervisor gates by both enables
// R5: isa bit 7 enables hypervisor, writable
// R6: 32 integer registers, trap value, translation
// R7: flag picks host or guest privilege set
// R8: nominal privilege U or S reported; code also reports M
// R9: rank levels; host user disables guest interrupts
// R10: hypervisor csrs reachable from machine and host supervisor only
// R11: guest running redirects supervisor csrs to copies
// R12: direct copy access traps virtual or illegal
// R13: copies addressable only from machine or host
// R14: host copies kept but inactive while guest
// R15: guest copies inert but accessible when host
// R16: no-copy supervisor csrs keep function under guest
// R17: overflow flag sticky until software writes
// R18: feature off forces flag zero, rejects accesses
`timescale 1ns/1ps
module hcac_csr #(
  parameter int XREGS       = hcac_pkg::XREG_COUNT,
  parameter bit TVAL_HARDWIRED = 1'b0,
  parameter bit PAGE_XLATE  = 1'b1
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // csr access from the pipeline
  input  wire logic        csr_req_i,
  input  wire logic        csr_we_i,
  input  wire logic [11:0] csr_addr_i,
  input  wire logic [31:0] csr_wdata_i,
  // csr answer
  output logic             csr_done_o,
  output logic [31:0]      csr_rdata_o,
  output logic             csr_illegal_o,
  output logic             csr_virtual_o,
  // privilege mode updates (trap entry, return)
  input  wire logic        mode_set_i,
  input  wire logic [1:0]  mode_priv_i,
  input  wire logic        mode_virt_i,
  // counter overflow events, one-cycle pulses per counter
  input  wire logic [31:0] ovf_event_i,
  // privilege state
  output logic             virt_o,
  output logic [1:0]       nominal_priv_o,
  output logic             two_stage_o,
  output logic             guest_irq_en_o,
  // active supervisor state seen by the hart
  output logic [31:0]      active_status_o,
  output logic [31:0]      active_atp_o
);

  localparam int NC = hcac_pkg::NCOPY;
  // reset release through two flops
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // state
  logic              isa_h;
  logic [31:0]       mcnten;
  logic [31:0]       hcnten;
  logic [31:0]       ovf_flag;
  logic [31:0]       scnten;
  logic [31:0]       senvcfg;
  logic [31:0]       scontext;
  logic [1:0]        priv;
  logic              virt;
  logic [31:0]       copy_mem [32];  // bank select is index bit 4, so each half keeps spare slots
  logic              done;
  logic [31:0]       rdata;
  logic              illegal;
  logic              virtual_exc;

  // decode results
  logic              hyp_or_vs;
  logic              ro_space;
  logic [1:0]        need_lvl;
  logic              copy_hit;
  logic [3:0]        copy_idx;
  logic              bank_guest;
  logic              known;
  logic              access_ok;
  logic [31:0]       shadow_rd;
  logic [31:0]       rd_mux;

  // next values
  logic              next_isa_h;
  logic [31:0]       next_mcnten;
  logic [31:0]       next_hcnten;
  logic [31:0]       next_ovf_flag;
  logic [31:0]       next_scnten;
  logic [31:0]       next_senvcfg;
  logic [31:0]       next_scontext;
  logic [1:0]        next_priv;
  logic              next_virt;
  logic              next_copy_we;
  logic [4:0]        next_copy_sel;
  logic              next_done;
  logic [31:0]       next_rdata;
  logic              next_illegal;
  logic              next_virtual;

  // address decode; supervisor copies redirect to the guest bank when running a guest
  always_comb begin
    hyp_or_vs  = (csr_addr_i[9:8] == hcac_pkg::PRIV_H);
    ro_space   = (csr_addr_i[11:10] == 2'h3);
    need_lvl   = hyp_or_vs ? hcac_pkg::PRIV_S : csr_addr_i[9:8];
    copy_hit   = 1'b0;
    copy_idx   = 4'h0;
    for (int i = 0; i < NC; i++) begin
      if (csr_addr_i[7:0] == hcac_pkg::COPY_LOW[i] &&
          (csr_addr_i[11:8] == hcac_pkg::PAGE_HOST || csr_addr_i[11:8] == hcac_pkg::PAGE_GUEST)) begin
        copy_hit = 1'b1;
        copy_idx = 4'(i);
      end
    end
    bank_guest = (csr_addr_i[11:8] == hcac_pkg::PAGE_GUEST) || virt; // [R11]
    known      = copy_hit || csr_addr_i == hcac_pkg::ADDR_ISA || csr_addr_i == hcac_pkg::ADDR_MCNTEN ||
                 csr_addr_i == hcac_pkg::ADDR_OVF_CTL || csr_addr_i == hcac_pkg::ADDR_SHADOW ||
                 csr_addr_i == hcac_pkg::ADDR_HCNTEN || csr_addr_i == hcac_pkg::ADDR_SCNTEN ||
                 csr_addr_i == hcac_pkg::ADDR_SENVCFG || csr_addr_i == hcac_pkg::ADDR_SCONTEXT;
  end

  // overflow shadow, read gating by privilege and counter enables
  always_comb begin
    if (priv == hcac_pkg::PRIV_M) begin
      shadow_rd = ovf_flag;                                  // [R2]
    end else if (!virt) begin
      shadow_rd = ovf_flag & mcnten;                         // [R3]
    end else begin
      shadow_rd = ovf_flag & mcnten & hcnten;                // [R4]
    end
  end

  // read data mux; hypervisor registers outside this block read zero
  always_comb begin
    rd_mux = hcac_pkg::CSR_RESET;
    if (copy_hit) begin
      rd_mux = copy_mem[{bank_guest, copy_idx}];
    end else if (csr_addr_i == hcac_pkg::ADDR_ISA) begin
      rd_mux = hcac_pkg::ISA_FIXED | (32'(isa_h) << hcac_pkg::ISA_H_BIT);
    end else if (csr_addr_i == hcac_pkg::ADDR_MCNTEN) begin
      rd_mux = mcnten;
    end else if (csr_addr_i == hcac_pkg::ADDR_OVF_CTL) begin
      rd_mux = ovf_flag;
    end else if (csr_addr_i == hcac_pkg::ADDR_SHADOW) begin
      rd_mux = shadow_rd;                                    // [R1]
    end else if (csr_addr_i == hcac_pkg::ADDR_HCNTEN) begin
      rd_mux = hcnten;
    end else if (csr_addr_i == hcac_pkg::ADDR_SCNTEN) begin
      rd_mux = scnten;                                       // [R16]
    end else if (csr_addr_i == hcac_pkg::ADDR_SENVCFG) begin
      rd_mux = senvcfg;
    end else if (csr_addr_i == hcac_pkg::ADDR_SCONTEXT) begin
      rd_mux = scontext;
    end
  end

  // access checks, first failing check decides the exception
  always_comb begin
    next_illegal = 1'b0;
    next_virtual = 1'b0;
    if (!isa_h && hyp_or_vs) begin
      next_illegal = 1'b1;                                   // [R18]
    end else if (priv < need_lvl) begin
      // guest levels trap virtual for s and h space, host user traps illegal
      next_virtual = virt && need_lvl != hcac_pkg::PRIV_M;   // [R12]
      next_illegal = !(virt && need_lvl != hcac_pkg::PRIV_M);
    end else if (virt && hyp_or_vs) begin
      next_virtual = 1'b1;                                   // [R10] [R12] [R13]
    end else if (ro_space && csr_we_i) begin
      next_illegal = 1'b1;
    end else if (!known) begin
      next_illegal = 1'b1;
    end
    access_ok  = csr_req_i && !next_illegal && !next_virtual;
    next_done  = csr_req_i;
    next_rdata = csr_req_i ? rd_mux : rdata;
    next_illegal = next_illegal && csr_req_i;
    next_virtual = next_virtual && csr_req_i;
  end

  // register writes; overflow events win over a software write
  always_comb begin
    next_isa_h    = isa_h;
    next_mcnten   = mcnten;
    next_hcnten   = hcnten;
    next_ovf_flag = ovf_flag;
    next_scnten   = scnten;
    next_senvcfg  = senvcfg;
    next_scontext = scontext;
    next_copy_we  = access_ok && csr_we_i && copy_hit;      // [R14] [R15]
    next_copy_sel = {bank_guest, copy_idx};
    if (access_ok && csr_we_i) begin
      if (csr_addr_i == hcac_pkg::ADDR_ISA) begin
        next_isa_h = csr_wdata_i[hcac_pkg::ISA_H_BIT];      // [R5]
      end else if (csr_addr_i == hcac_pkg::ADDR_MCNTEN) begin
        next_mcnten = csr_wdata_i;
      end else if (csr_addr_i == hcac_pkg::ADDR_OVF_CTL) begin
        next_ovf_flag = csr_wdata_i & hcac_pkg::OVF_MASK;
      end else if (csr_addr_i == hcac_pkg::ADDR_HCNTEN) begin
        next_hcnten = csr_wdata_i;
      end else if (csr_addr_i == hcac_pkg::ADDR_SCNTEN) begin
        next_scnten = csr_wdata_i;                           // [R16]
      end else if (csr_addr_i == hcac_pkg::ADDR_SENVCFG) begin
        next_senvcfg = csr_wdata_i;
      end else if (csr_addr_i == hcac_pkg::ADDR_SCONTEXT) begin
        next_scontext = csr_wdata_i;
      end
    end
    next_ovf_flag = next_ovf_flag | (ovf_event_i & hcac_pkg::OVF_MASK); // [R17]
  end

  // privilege tracking; a guest never sits at machine level
  always_comb begin
    next_priv = priv;
    next_virt = virt;
    if (mode_set_i) begin
      next_priv = (mode_priv_i == hcac_pkg::PRIV_H) ? hcac_pkg::PRIV_U : mode_priv_i;
      next_virt = mode_virt_i;
    end
    if (!next_isa_h || next_priv == hcac_pkg::PRIV_M) begin
      next_virt = 1'b0;                                      // [R7] [R18]
    end
  end

  // state registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      isa_h       <= hcac_pkg::ISA_H_RESET;
      mcnten      <= hcac_pkg::CSR_RESET;
      hcnten      <= hcac_pkg::CSR_RESET;
      ovf_flag    <= hcac_pkg::CSR_RESET;
      scnten      <= hcac_pkg::CSR_RESET;
      senvcfg     <= hcac_pkg::CSR_RESET;
      scontext    <= hcac_pkg::CSR_RESET;
      priv        <= hcac_pkg::PRIV_M;
      virt        <= 1'b0;
      done        <= 1'b0;
      rdata       <= hcac_pkg::CSR_RESET;
      illegal     <= 1'b0;
      virtual_exc <= 1'b0;
    end else begin
      isa_h       <= next_isa_h;
      mcnten      <= next_mcnten;
      hcnten      <= next_hcnten;
      ovf_flag    <= next_ovf_flag;
      scnten      <= next_scnten;
      senvcfg     <= next_senvcfg;
      scontext    <= next_scontext;
      priv        <= next_priv;
      virt        <= next_virt;
      done        <= next_done;
      rdata       <= next_rdata;
      illegal     <= next_illegal;
      virtual_exc <= next_virtual;
    end
  end

  // both supervisor banks; host and guest copies each keep their own values
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        copy_mem[i] <= hcac_pkg::CSR_RESET;
      end
    end else if (next_copy_we) begin
      copy_mem[next_copy_sel] <= csr_wdata_i;                // [R11]
    end
  end

  // outputs; only the bank selected by the flag drives hart behaviour
  assign csr_done_o      = done;
  assign csr_rdata_o     = rdata;
  assign csr_illegal_o   = illegal;
  assign csr_virtual_o   = virtual_exc;
  assign virt_o          = virt;
  assign two_stage_o     = virt;                             // [R7]
  assign nominal_priv_o  = priv;                             // [R8]
  assign active_status_o = copy_mem[{virt, 4'(hcac_pkg::IDX_STATUS)}]; // [R14] [R15]
  assign active_atp_o    = copy_mem[{virt, 4'(hcac_pkg::IDX_ATP)}];
  // host supervisor outranks guests; host user masks guest interrupts
  assign guest_irq_en_o  = virt ? (priv == hcac_pkg::PRIV_U ||
                                   active_status_o[hcac_pkg::STATUS_SIE])
                                : (priv != hcac_pkg::PRIV_U);           // [R9]

  // a guest writing the supervisor status address
  sequence s_guest_status_write;
    csr_req_i && csr_we_i && virt && priv == hcac_pkg::PRIV_S && csr_addr_i == 12'h100;
  endsequence
  sequence s_shadow_read;
    csr_req_i && !csr_we_i && csr_addr_i == hcac_pkg::ADDR_SHADOW;
  endsequence
  a_base_config: assert property (@(posedge clk_i) disable iff (!rst_n) // [R6]
    XREGS == 32 && !TVAL_HARDWIRED && PAGE_XLATE) else $error("hart base config unfit for hypervisor");
  a_ovf_sticky: assert property (@(posedge clk_i) disable iff (!rst_n) // [R17]
    |(ovf_event_i & hcac_pkg::OVF_MASK) |=> ((ovf_flag & $past(ovf_event_i & hcac_pkg::OVF_MASK))
      == $past(ovf_event_i & hcac_pkg::OVF_MASK))) else $error("overflow event lost");
  a_shadow_mach: assert property (@(posedge clk_i) disable iff (!rst_n) // [R2]
    s_shadow_read and (priv == hcac_pkg::PRIV_M) |=> csr_done_o && !csr_illegal_o &&
      csr_rdata_o == $past(ovf_flag)) else $error("machine shadow read gated");
  a_shadow_host: assert property (@(posedge clk_i) disable iff (!rst_n) // [R3]
    s_shadow_read and (priv == hcac_pkg::PRIV_S && !virt) |=>
      csr_rdata_o == ($past(ovf_flag) & $past(mcnten))) else $error("host shadow gating wrong");
  a_shadow_guest: assert property (@(posedge clk_i) disable iff (!rst_n) // [R4]
    s_shadow_read and (priv == hcac_pkg::PRIV_S && virt) |=>
      csr_rdata_o == ($past(ovf_flag) & $past(mcnten) & $past(hcnten))) else $error("guest shadow gating wrong");
  a_guest_legal: assert property (@(posedge clk_i) disable iff (!rst_n) // [R7] [R18]
    virt |-> isa_h && priv != hcac_pkg::PRIV_M) else $error("guest flag in illegal level");
  a_copy_direct: assert property (@(posedge clk_i) disable iff (!rst_n) // [R10] [R12] [R13]
    csr_req_i && virt && priv == hcac_pkg::PRIV_S && csr_addr_i[9:8] == 2'h2 |=>
      csr_done_o && csr_virtual_o && !csr_illegal_o) else $error("guest reached hypervisor space");
  a_user_illegal: assert property (@(posedge clk_i) disable iff (!rst_n) // [R12]
    csr_req_i && !virt && priv == hcac_pkg::PRIV_U && csr_addr_i[9:8] != 2'h0 |=>
      csr_illegal_o && !csr_virtual_o) else $error("host user access not illegal");
  a_guest_redirect: assert property (@(posedge clk_i) disable iff (!rst_n) // [R11] [R14]
    s_guest_status_write |=> active_status_o == $past(csr_wdata_i) &&
      copy_mem[hcac_pkg::IDX_STATUS] == $past(copy_mem[hcac_pkg::IDX_STATUS]))
    else $error("guest status write not redirected");
  a_feature_off: assert property (@(posedge clk_i) disable iff (!rst_n) // [R18]
    csr_req_i && !isa_h && csr_addr_i[9:8] == 2'h2 |=> csr_illegal_o) else $error("feature off access allowed");
  a_nominal_priv: assert property (@(posedge clk_i) disable iff (!rst_n) // [R8]
    mode_set_i && mode_priv_i == hcac_pkg::PRIV_S |=> nominal_priv_o == hcac_pkg::PRIV_S)
    else $error("nominal privilege wrong");
endmodule

/* hcac_pkg.sv */
// Purpose: shared constants of the hypervisor csr access control block
// Assumes: 32-bit csr data, 12-bit csr addresses
// Notes:   csr addresses are plain defaults and may be adjusted per core
package hcac_pkg;

  // data and counter geometry
  localparam int          XLEN          = 32;
  localparam int          XREG_COUNT    = 32;
  localparam int          OVF_FIRST     = 3;
  localparam logic [31:0] OVF_MASK      = 32'hFFFF_FFF8;

  // nominal privilege encoding
  localparam logic [1:0]  PRIV_U        = 2'h0;
  localparam logic [1:0]  PRIV_S        = 2'h1;
  localparam logic [1:0]  PRIV_H        = 2'h2;
  localparam logic [1:0]  PRIV_M        = 2'h3;

  // isa configuration: hypervisor enable bit
  localparam int          ISA_H_BIT     = 7;
  localparam logic        ISA_H_RESET   = 1'b1;
  localparam logic [31:0] ISA_FIXED     = 32'h4000_1100;

  // machine, counter and supervisor csr addresses
  localparam logic [11:0] ADDR_ISA      = 12'h301;
  localparam logic [11:0] ADDR_MCNTEN   = 12'h306;
  localparam logic [11:0] ADDR_OVF_CTL  = 12'h7C0;
  localparam logic [11:0] ADDR_SHADOW   = 12'hDA0;
  localparam logic [11:0] ADDR_HCNTEN   = 12'h606;
  localparam logic [11:0] ADDR_SCNTEN   = 12'h106;
  localparam logic [11:0] ADDR_SENVCFG  = 12'h10A;
  localparam logic [11:0] ADDR_SCONTEXT = 12'h5A8;

  // supervisor csrs that own a guest copy: host at 0x1xx, guest at 0x2xx
  localparam int          NCOPY         = 9;
  localparam logic [3:0]  PAGE_HOST     = 4'h1;
  localparam logic [3:0]  PAGE_GUEST    = 4'h2;
  localparam logic [7:0]  COPY_LOW [NCOPY] = '{8'h00, 8'h04, 8'h05, 8'h40, 8'h41,
                                                8'h42, 8'h43, 8'h44, 8'h80};
  localparam int          IDX_STATUS    = 0;
  localparam int          IDX_ATP       = 8;
  localparam int          STATUS_SIE    = 1;

  // reset values
  localparam logic [31:0] CSR_RESET     = 32'h0000_0000;

endpackage

/* hcac_pipe_model.sv */
// Purpose: pipeline model that issues csr accesses and privilege changes
// Assumes: one request pulse per access, answer one cycle later
// Notes:   released request lines carry inverted values, never stale ones
`timescale 1ns/1ps
module hcac_pipe_model (
  // clock
  input  wire logic        clk_i,
  // csr request
  output logic             csr_req_o,
  output logic             csr_we_o,
  output logic [11:0]      csr_addr_o,
  output logic [31:0]      csr_wdata_o,
  // csr answer
  input  wire logic        csr_done_i,
  input  wire logic [31:0] csr_rdata_i,
  input  wire logic        csr_illegal_i,
  input  wire logic        csr_virtual_i,
  // privilege change
  output logic             mode_set_o,
  output logic [1:0]       mode_priv_o,
  output logic             mode_virt_o
);
  // idle values at time zero
  initial begin
    csr_req_o   = 1'b0;
    csr_we_o    = 1'b0;
    csr_addr_o  = 12'h000;
    csr_wdata_o = 32'h0000_0000;
    mode_set_o  = 1'b0;
    mode_priv_o = 2'h3;
    mode_virt_o = 1'b0;
  end

  // one access; request stands over exactly one rising edge
  task automatic access(input logic we, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic [1:0] exc, output logic got);
    got   = 1'b0;
    rdata = 32'h0000_0000;
    exc   = 2'h3;
    @(negedge clk_i);
    csr_req_o   = 1'b1;
    csr_we_o    = we;
    csr_addr_o  = addr;
    csr_wdata_o = wdata;
    @(negedge clk_i);
    csr_req_o   = 1'b0;
    csr_we_o    = ~we;
    csr_addr_o  = ~addr;
    csr_wdata_o = ~wdata;
    // bounded wait, the answer is due at once
    for (int n = 0; n < 4 && !got; n++) begin
      if (csr_done_i === 1'b1) begin
        got   = 1'b1;
        rdata = csr_rdata_i;
        exc   = {csr_virtual_i, csr_illegal_i};
      end else begin
        @(negedge clk_i);
      end
    end
  endtask

  // privilege change as a trap entry or return would do it
  task automatic set_mode(input logic [1:0] priv, input logic virt);
    @(negedge clk_i);
    mode_set_o  = 1'b1;
    mode_priv_o = priv;
    mode_virt_o = virt;
    @(negedge clk_i);
    mode_set_o  = 1'b0;
    mode_priv_o = ~priv;
    mode_virt_o = ~virt;
    repeat (2) @(negedge clk_i);
  endtask
endmodule

/* hypervisor_csr_access_control_test.sv */
// Purpose: self-checking bench for csr steering, privilege and overflow shadow
// Assumes: design defaults, hypervisor feature on after reset
// Notes:   expectations come from the access rules and package constants
`timescale 1ns/1ps
module hypervisor_csr_access_control_test;
  // answer codes as {virtual, illegal}
  localparam logic [1:0] OK  = 2'h0;
  localparam logic [1:0] ILL = 2'h1;
  localparam logic [1:0] VI  = 2'h2;

  // design wires
  logic        clk;
  logic        rst_n;
  logic [31:0] ovf_event;
  logic        csr_req;
  logic        csr_we;
  logic [11:0] csr_addr;
  logic [31:0] csr_wdata;
  logic        csr_done;
  logic [31:0] csr_rdata;
  logic        csr_illegal;
  logic        csr_virtual;
  logic        mode_set;
  logic [1:0]  mode_priv;
  logic        mode_virt;
  logic        virt;
  logic [1:0]  nominal_priv;
  logic        two_stage;
  logic        guest_irq_en;
  logic [31:0] active_status;
  logic [31:0] active_atp;
  logic [31:0] rd;
  int          mismatches = 0;
  int          n_compared = 0;

  hcac_csr i_hcac_csr (.clk_i(clk), .rst_n_i(rst_n), .csr_req_i(csr_req), .csr_we_i(csr_we),
    .csr_addr_i(csr_addr), .csr_wdata_i(csr_wdata), .csr_done_o(csr_done), .csr_rdata_o(csr_rdata),
    .csr_illegal_o(csr_illegal), .csr_virtual_o(csr_virtual), .mode_set_i(mode_set),
    .mode_priv_i(mode_priv), .mode_virt_i(mode_virt), .ovf_event_i(ovf_event), .virt_o(virt),
    .nominal_priv_o(nominal_priv), .two_stage_o(two_stage), .guest_irq_en_o(guest_irq_en),
    .active_status_o(active_status), .active_atp_o(active_atp));

  hcac_pipe_model i_hcac_pipe_model (.clk_i(clk), .csr_req_o(csr_req), .csr_we_o(csr_we),
    .csr_addr_o(csr_addr), .csr_wdata_o(csr_wdata), .csr_done_i(csr_done), .csr_rdata_i(csr_rdata),
    .csr_illegal_i(csr_illegal), .csr_virtual_i(csr_virtual), .mode_set_o(mode_set),
    .mode_priv_o(mode_priv), .mode_virt_o(mode_virt));

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one access with its expected exception; read data lands in rd
  task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] wd, input logic [1:0] ex);
    logic [1:0] e;
    logic       g;
    i_hcac_pipe_model.access(we, a, wd, rd, e, g);
    check("csr_done", {31'h0, g}, 32'h1);
    check("csr_exception", {30'h0, e}, {30'h0, ex});
  endtask

  // counter overflow pulse of one cycle
  task automatic overflow(input logic [31:0] ev);
    @(negedge clk);
    ovf_event = ev;
    @(negedge clk);
    ovf_event = 32'h0000_0000;
  endtask

  task automatic mode_row(input logic [1:0] p, input logic v, input logic ev, input logic [1:0] np,
                          input logic irq);
    i_hcac_pipe_model.set_mode(p, v);
    check("virt", {31'h0, virt}, {31'h0, ev});
    check("two_stage", {31'h0, two_stage}, {31'h0, ev});
    check("nominal_priv", {30'h0, nominal_priv}, {30'h0, np});
    check("guest_irq_en", {31'h0, guest_irq_en}, {31'h0, irq});
  endtask

  task automatic t_reset();
    check("virt", {31'h0, virt}, 32'h0);
    check("nominal_priv", {30'h0, nominal_priv}, {30'h0, hcac_pkg::PRIV_M});
    acc(1'b0, hcac_pkg::ADDR_ISA, 32'h0, OK);
    check("isa", rd, hcac_pkg::ISA_FIXED | 32'h0000_0080);
  endtask

  // all level combinations except encoding 2 with the guest flag; guest status is still zero here
  task automatic t_modes();
    mode_row(2'h3, 1'b1, 1'b0, 2'h3, 1'b1);
    mode_row(2'h1, 1'b0, 1'b0, 2'h1, 1'b1);
    mode_row(2'h0, 1'b0, 1'b0, 2'h0, 1'b0);
    mode_row(2'h1, 1'b1, 1'b1, 2'h1, 1'b0);
    mode_row(2'h0, 1'b1, 1'b1, 2'h0, 1'b1);
    mode_row(2'h2, 1'b0, 1'b0, 2'h0, 1'b0);
    mode_row(2'h3, 1'b0, 1'b0, 2'h3, 1'b1);
    acc(1'b1, 12'h200, 32'h0000_0002, OK);
    i_hcac_pipe_model.set_mode(2'h1, 1'b1);
    check("guest_irq_en", {31'h0, guest_irq_en}, 32'h1);
    check("active_status", active_status, 32'h0000_0002);
    acc(1'b1, 12'h100, 32'h0000_0000, OK);
    check("guest_irq_en", {31'h0, guest_irq_en}, 32'h0);
    i_hcac_pipe_model.set_mode(2'h3, 1'b0);
  endtask

  task automatic t_shadow();
    acc(1'b1, hcac_pkg::ADDR_MCNTEN, 32'h00FF_00FF, OK);
    acc(1'b1, hcac_pkg::ADDR_HCNTEN, 32'h0F0F_0F0F, OK);
    overflow(32'hFFFF_FFFF);
    acc(1'b0, hcac_pkg::ADDR_SHADOW, 32'h0, OK);
    check("shadow_m", rd, 32'hFFFF_FFF8);
    i_hcac_pipe_model.set_mode(2'h1, 1'b0);
    acc(1'b0, hcac_pkg::ADDR_SHADOW, 32'h0, OK);
    check("shadow_hs", rd, 32'h00FF_00F8);
    i_hcac_pipe_model.set_mode(2'h1, 1'b1);
    acc(1'b0, hcac_pkg::ADDR_SHADOW, 32'h0, OK);
    check("shadow_vs", rd, 32'h000F_0008);
    i_hcac_pipe_model.set_mode(2'h3, 1'b0);
    acc(1'b1, hcac_pkg::ADDR_OVF_CTL, 32'h0, OK);
    acc(1'b0, hcac_pkg::ADDR_SHADOW, 32'h0, OK);
    check("shadow_clear", rd, 32'h0);
    overflow(32'h0000_0022);
    repeat (5) @(negedge clk);
    acc(1'b0, hcac_pkg::ADDR_SHADOW, 32'h0, OK);
    check("shadow_sticky", rd, 32'h0000_0020);
    acc(1'b1, hcac_pkg::ADDR_SHADOW, 32'hFFFF_FFFF, ILL);
  endtask

  // host and guest translation copies, direct and redirected access
  task automatic t_subst();
    acc(1'b1, 12'h180, 32'h1111_0000, OK);
    acc(1'b1, 12'h280, 32'h2222_0000, OK);
    check("active_atp", active_atp, 32'h1111_0000);
    i_hcac_pipe_model.set_mode(2'h1, 1'b0);
    acc(1'b0, 12'h280, 32'h0, OK);
    check("guest_copy", rd, 32'h2222_0000);
    i_hcac_pipe_model.set_mode(2'h1, 1'b1);
    check("active_atp", active_atp, 32'h2222_0000);
    acc(1'b0, 12'h180, 32'h0, OK);
    check("redirect", rd, 32'h2222_0000);
    acc(1'b1, 12'h180, 32'h3333_0000, OK);
    acc(1'b0, 12'h280, 32'h0, VI);
    acc(1'b1, hcac_pkg::ADDR_HCNTEN, 32'h0, VI);
    i_hcac_pipe_model.set_mode(2'h0, 1'b1);
    acc(1'b0, 12'h280, 32'h0, VI);
    i_hcac_pipe_model.set_mode(2'h0, 1'b0);
    acc(1'b0, 12'h280, 32'h0, ILL);
    acc(1'b0, hcac_pkg::ADDR_HCNTEN, 32'h0, ILL);
    i_hcac_pipe_model.set_mode(2'h3, 1'b0);
    acc(1'b0, 12'h180, 32'h0, OK);
    check("host_copy", rd, 32'h1111_0000);
    acc(1'b0, 12'h280, 32'h0, OK);
    check("guest_copy", rd, 32'h3333_0000);
    acc(1'b0, 12'h7FF, 32'h0, ILL);
  endtask

  // no guest copy: guest writes land in the one shared register
  task automatic t_nocopy();
    logic [11:0] a [3];
    a = '{hcac_pkg::ADDR_SCNTEN, hcac_pkg::ADDR_SENVCFG, hcac_pkg::ADDR_SCONTEXT};
    foreach (a[i]) begin
      i_hcac_pipe_model.set_mode(2'h1, 1'b1);
      acc(1'b1, a[i], 32'h0000_0001, OK);
      i_hcac_pipe_model.set_mode(2'h3, 1'b0);
      acc(1'b0, a[i], 32'h0, OK);
      check("shared_csr", rd, 32'h0000_0001);
    end
  endtask

  task automatic t_feature();
    acc(1'b1, hcac_pkg::ADDR_ISA, 32'h0, OK);
    acc(1'b0, hcac_pkg::ADDR_ISA, 32'h0, OK);
    check("isa_off", rd, hcac_pkg::ISA_FIXED);
    i_hcac_pipe_model.set_mode(2'h1, 1'b1);
    check("virt_off", {31'h0, virt}, 32'h0);
    i_hcac_pipe_model.set_mode(2'h3, 1'b0);
    acc(1'b0, 12'h280, 32'h0, ILL);
    acc(1'b0, hcac_pkg::ADDR_HCNTEN, 32'h0, ILL);
    acc(1'b1, hcac_pkg::ADDR_ISA, 32'h0000_0080, OK);
    acc(1'b0, 12'h280, 32'h0, OK);
  endtask

  // watchdog well beyond the few hundred cycles needed
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  // reset, then the scenarios in order
  initial begin
    rst_n     = 1'b0;
    ovf_event = 32'h0000_0000;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_modes();
    t_shadow();
    t_subst();
    t_nocopy();
    t_feature();
    end_of_test();
  end
endmodule
